// ===== serial_port.sv
// Purpose: full-duplex asynchronous serial port
// Assumes: all inputs synchronous to sys_clk; bit_div >= 4
// Notes: plain ports stand in for control and status registers
`include "serial_port_defs.svh"
module serial_port #(
  parameter int FIFO_LOG = `RX_FIFO_LOG
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // configuration
  input wire logic [15:0] bit_div,
  input wire logic [1:0] word_len,
  input wire logic parity_en,
  input wire logic parity_odd,
  input wire logic multidrop_bus_mode,
  input wire logic [7:0] node_addr,
  input wire logic two_stop,
  input wire logic auto_flow,
  input wire logic [FIFO_LOG:0] rts_level,
  input wire logic [7:0] break_len,
  input wire logic [7:0] ifs_len,
  input wire logic ir_mode,
  // transmit data
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_addr,
  input wire logic tx_break,
  output logic tx_dma_req,
  // receive data
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  output logic rx_addr,
  output logic rx_dma_req,
  output logic rx_attn,
  // status flags
  output logic parity_err,
  output logic frame_err,
  output logic break_seen,
  output logic overrun,
  input wire logic [3:0] err_clr,
  // serial pins
  output logic txd,
  input wire logic rxd,
  output logic ir_txd,
  input wire logic ir_rxd,
  input wire logic cts_n,
  output logic rts_n
);
  serial_port_pkg::tx_state_t tx_st_ff, nxt_tx_st;
  serial_port_pkg::rx_state_t rx_st_ff, nxt_rx_st;
  logic [15:0] tx_cnt_ff, nxt_tx_cnt, rx_cnt_ff, nxt_rx_cnt, ir_st_ff, nxt_ir_st;
  logic [7:0] tx_bit_ff, nxt_tx_bit, rx_bit_ff, nxt_rx_bit;
  logic [7:0] hold_ff, nxt_hold, tx_sh_ff, nxt_tx_sh, rx_sh_ff, nxt_rx_sh;
  logic hold_full_ff, nxt_hold_full, hold_addr_ff, nxt_hold_addr, hold_brk_ff, nxt_hold_brk;
  logic tx_xbit_ff, nxt_tx_xbit, tx_line_ff, nxt_tx_line, ir_tx_ff, nxt_ir_tx;
  logic rx_xbit_ff, nxt_rx_xbit, rx_stoplow_ff, nxt_rx_stoplow;
  logic push_ff, nxt_push, push_addr_ff, nxt_push_addr, attn_ff, nxt_attn;
  logic [7:0] push_data_ff, nxt_push_data;
  logic sel_ff, nxt_sel;
  logic [3:0] flag_ff, nxt_flag, flag_set;
  logic [7:0] nbits, stop_cnt;
  logic xbit_on, tx_end, rx_end, rx_mid, rx_in, fifo_in_ready;
  logic [FIFO_LOG:0] fifo_count;
  logic [`RX_WORD_W-1:0] fifo_out;
  logic [15:0] ir_w;

  // parity over the active character bits
  function automatic logic par_calc(input logic [7:0] d, input logic [7:0] n, input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < `DATA_W; i++) begin
      if (8'(i) < n) begin
        p = p ^ d[i];
      end
    end
    return p;
  endfunction

  assign nbits = 8'({2'b00, word_len}) + 8'(`WLEN_BASE);
  assign stop_cnt = two_stop ? 8'h02 : 8'h01;
  assign xbit_on = parity_en || multidrop_bus_mode;
  assign tx_end = (tx_cnt_ff == bit_div - 16'h0001);
  assign rx_end = (rx_cnt_ff == bit_div - 16'h0001);
  assign rx_mid = (rx_cnt_ff == (bit_div >> 1));
  assign ir_w = ((bit_div * `IR_NUM) >> `IR_SHIFT) | 16'h0001;
  assign tx_ready = !hold_full_ff;
  assign tx_dma_req = !hold_full_ff;
  assign rx_dma_req = rx_valid;
  // infrared receive: a pulse marks a zero for one bit time
  assign rx_in = ir_mode ? (ir_st_ff == `CNT_ZERO && !ir_rxd) : rxd;
  assign txd = tx_line_ff;
  assign ir_txd = ir_tx_ff;
  assign rts_n = auto_flow && (fifo_count >= rts_level);
  assign rx_data = fifo_out[7:0];
  assign rx_addr = fifo_out[`DATA_W];
  assign rx_attn = attn_ff;
  assign parity_err = flag_ff[0];
  assign frame_err = flag_ff[1];
  assign break_seen = flag_ff[2];
  assign overrun = flag_ff[3];

  // transmit path
  always_comb begin
    nxt_tx_st = tx_st_ff;
    nxt_tx_cnt = (tx_st_ff == serial_port_pkg::TX_IDLE || tx_end) ? `CNT_ZERO : tx_cnt_ff + 16'h0001;
    nxt_tx_bit = tx_bit_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_xbit = tx_xbit_ff;
    nxt_tx_line = tx_line_ff;
    nxt_hold = hold_ff;
    nxt_hold_full = hold_full_ff;
    nxt_hold_addr = hold_addr_ff;
    nxt_hold_brk = hold_brk_ff;
    if (tx_valid && !hold_full_ff) begin
      nxt_hold = tx_data;
      nxt_hold_addr = tx_addr;
      nxt_hold_brk = tx_break;
      nxt_hold_full = 1'b1;
    end
    unique case (tx_st_ff)
      serial_port_pkg::TX_IDLE: begin
        nxt_tx_line = `LINE_IDLE;
        if (hold_full_ff && (!auto_flow || !cts_n)) begin
          nxt_hold_full = 1'b0;
          nxt_tx_sh = hold_ff;
          nxt_tx_xbit = multidrop_bus_mode ? hold_addr_ff : par_calc(hold_ff, nbits, parity_odd);
          nxt_tx_bit = `BIT_ZERO;
          nxt_tx_line = 1'b0;
          nxt_tx_st = hold_brk_ff ? serial_port_pkg::TX_BRK : serial_port_pkg::TX_START;
        end
      end
      serial_port_pkg::TX_START: begin
        if (tx_end) begin
          nxt_tx_line = tx_sh_ff[0];
          nxt_tx_st = serial_port_pkg::TX_DATA;
        end
      end
      serial_port_pkg::TX_DATA: begin
        if (tx_end) begin
          nxt_tx_sh = tx_sh_ff >> 1;
          nxt_tx_bit = tx_bit_ff + 8'h01;
          nxt_tx_line = tx_sh_ff[1];
          if (tx_bit_ff == nbits - 8'h01) begin
            nxt_tx_bit = `BIT_ZERO;
            nxt_tx_line = xbit_on ? tx_xbit_ff : `LINE_IDLE;
            nxt_tx_st = xbit_on ? serial_port_pkg::TX_PAR : serial_port_pkg::TX_STOP;
          end
        end
      end
      serial_port_pkg::TX_PAR: begin
        if (tx_end) begin
          nxt_tx_line = `LINE_IDLE;
          nxt_tx_st = serial_port_pkg::TX_STOP;
        end
      end
      serial_port_pkg::TX_STOP: begin
        if (tx_end) begin
          nxt_tx_bit = tx_bit_ff + 8'h01;
          if (tx_bit_ff == stop_cnt - 8'h01) begin
            nxt_tx_bit = `BIT_ZERO;
            nxt_tx_st = (ifs_len != `BIT_ZERO) ? serial_port_pkg::TX_IFS : serial_port_pkg::TX_IDLE;
          end
        end
      end
      serial_port_pkg::TX_IFS: begin
        if (tx_end) begin
          nxt_tx_bit = tx_bit_ff + 8'h01;
          if (tx_bit_ff == ifs_len - 8'h01) begin
            nxt_tx_st = serial_port_pkg::TX_IDLE;
          end
        end
      end
      serial_port_pkg::TX_BRK: begin
        if (tx_end) begin
          nxt_tx_bit = tx_bit_ff + 8'h01;
          if (break_len == `BIT_ZERO || tx_bit_ff >= break_len - 8'h01) begin
            nxt_tx_bit = `BIT_ZERO;
            nxt_tx_line = `LINE_IDLE;
            nxt_tx_st = serial_port_pkg::TX_STOP;
          end
        end
      end
    endcase
    // infrared send: zero bits become a short high pulse
    nxt_ir_tx = ir_mode && !tx_line_ff && (tx_cnt_ff < ir_w);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_st_ff <= serial_port_pkg::TX_IDLE;
      tx_cnt_ff <= `CNT_ZERO;
      tx_bit_ff <= `BIT_ZERO;
      tx_sh_ff <= `BIT_ZERO;
      tx_xbit_ff <= 1'b0;
      tx_line_ff <= `LINE_IDLE;
      ir_tx_ff <= 1'b0;
      hold_ff <= `BIT_ZERO;
      hold_full_ff <= 1'b0;
      hold_addr_ff <= 1'b0;
      hold_brk_ff <= 1'b0;
    end else begin
      tx_st_ff <= nxt_tx_st;
      tx_cnt_ff <= nxt_tx_cnt;
      tx_bit_ff <= nxt_tx_bit;
      tx_sh_ff <= nxt_tx_sh;
      tx_xbit_ff <= nxt_tx_xbit;
      tx_line_ff <= nxt_tx_line;
      ir_tx_ff <= nxt_ir_tx;
      hold_ff <= nxt_hold;
      hold_full_ff <= nxt_hold_full;
      hold_addr_ff <= nxt_hold_addr;
      hold_brk_ff <= nxt_hold_brk;
    end
  end

  // receive path
  always_comb begin
    nxt_rx_st = rx_st_ff;
    nxt_rx_cnt = (rx_st_ff == serial_port_pkg::RX_IDLE || rx_end) ? `CNT_ZERO : rx_cnt_ff + 16'h0001;
    nxt_rx_bit = rx_bit_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_xbit = rx_xbit_ff;
    nxt_rx_stoplow = rx_stoplow_ff;
    nxt_push = 1'b0;
    nxt_push_data = push_data_ff;
    nxt_push_addr = push_addr_ff;
    nxt_attn = 1'b0;
    nxt_sel = sel_ff;
    flag_set = 4'h0;
    nxt_ir_st = ir_st_ff;
    if (ir_rxd) begin
      nxt_ir_st = bit_div;
    end else if (ir_st_ff != `CNT_ZERO) begin
      nxt_ir_st = ir_st_ff - 16'h0001;
    end
    unique case (rx_st_ff)
      serial_port_pkg::RX_IDLE: begin
        if (!rx_in) begin
          nxt_rx_st = serial_port_pkg::RX_START;
          nxt_rx_sh = `BIT_ZERO;
          nxt_rx_bit = `BIT_ZERO;
          nxt_rx_stoplow = 1'b0;
        end
      end
      serial_port_pkg::RX_START: begin
        if (rx_mid) begin
          nxt_rx_cnt = `CNT_ZERO;
          nxt_rx_st = rx_in ? serial_port_pkg::RX_IDLE : serial_port_pkg::RX_DATA;
        end
      end
      serial_port_pkg::RX_DATA: begin
        if (rx_end) begin
          nxt_rx_sh[rx_bit_ff[2:0]] = rx_in;
          nxt_rx_bit = rx_bit_ff + 8'h01;
          if (rx_bit_ff == nbits - 8'h01) begin
            nxt_rx_bit = `BIT_ZERO;
            nxt_rx_st = xbit_on ? serial_port_pkg::RX_PAR : serial_port_pkg::RX_STOP;
          end
        end
      end
      serial_port_pkg::RX_PAR: begin
        if (rx_end) begin
          nxt_rx_xbit = rx_in;
          nxt_rx_st = serial_port_pkg::RX_STOP;
        end
      end
      serial_port_pkg::RX_STOP: begin
        if (rx_end) begin
          nxt_rx_stoplow = rx_stoplow_ff || !rx_in;
          nxt_rx_bit = rx_bit_ff + 8'h01;
          if (rx_bit_ff == stop_cnt - 8'h01) begin
            nxt_rx_st = serial_port_pkg::RX_IDLE;
            flag_set[0] = parity_en && !multidrop_bus_mode
                          && (rx_xbit_ff != par_calc(rx_sh_ff, nbits, parity_odd));
            flag_set[1] = nxt_rx_stoplow;
            flag_set[2] = nxt_rx_stoplow && rx_sh_ff == `BIT_ZERO && !(xbit_on && rx_xbit_ff);
            if (multidrop_bus_mode && rx_xbit_ff) begin
              nxt_sel = (rx_sh_ff == node_addr);
            end
            nxt_push = !multidrop_bus_mode || (rx_xbit_ff ? rx_sh_ff == node_addr : sel_ff);
            nxt_attn = nxt_push;
            nxt_push_data = rx_sh_ff;
            nxt_push_addr = multidrop_bus_mode ? rx_xbit_ff : 1'b0;
          end
        end
      end
    endcase
    flag_set[3] = push_ff && !fifo_in_ready;
    // a new event wins over a clear in the same cycle
    nxt_flag = flag_set | (flag_ff & ~err_clr);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_st_ff <= serial_port_pkg::RX_IDLE;
      rx_cnt_ff <= `CNT_ZERO;
      rx_bit_ff <= `BIT_ZERO;
      rx_sh_ff <= `BIT_ZERO;
      rx_xbit_ff <= 1'b0;
      rx_stoplow_ff <= 1'b0;
      push_ff <= 1'b0;
      push_data_ff <= `BIT_ZERO;
      push_addr_ff <= 1'b0;
      attn_ff <= 1'b0;
      sel_ff <= 1'b0;
      flag_ff <= 4'h0;
      ir_st_ff <= `CNT_ZERO;
    end else begin
      rx_st_ff <= nxt_rx_st;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_bit_ff <= nxt_rx_bit;
      rx_sh_ff <= nxt_rx_sh;
      rx_xbit_ff <= nxt_rx_xbit;
      rx_stoplow_ff <= nxt_rx_stoplow;
      push_ff <= nxt_push;
      push_data_ff <= nxt_push_data;
      push_addr_ff <= nxt_push_addr;
      attn_ff <= nxt_attn;
      sel_ff <= nxt_sel;
      flag_ff <= nxt_flag;
      ir_st_ff <= nxt_ir_st;
    end
  end

  rx_fifo_buf #(
    .WIDTH(`RX_WORD_W),
    .DEPTH_LOG(FIFO_LOG)
  ) u_rx_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(push_ff),
    .in_ready(fifo_in_ready),
    .in_data({push_addr_ff, push_data_ff}),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(fifo_out),
    .count(fifo_count)
  );
endmodule

// ===== serial_port_defs.svh
// Purpose: shared constants for the asynchronous serial port
// Assumes: included by bare name
// Notes: all timing counts are in sys_clk cycles
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH

// fewest data bits; word_len code adds to this
`define WLEN_BASE 4'h5
// widest character
`define DATA_W 8
// receive word: multidrop address bit above data, zero outside multidrop mode
`define RX_WORD_W 9
// fifo depth as log2
`define RX_FIFO_LOG 4
// default clocks per bit (100 MHz / 115200)
`define DEF_BIT_DIV 16'h0364
// infrared pulse is 3/16 of a bit time
`define IR_NUM 16'h0003
`define IR_SHIFT 4
// reset values
`define LINE_IDLE 1'b1
`define CNT_ZERO 16'h0000
`define BIT_ZERO 8'h00

`endif

// ===== serial_port_pkg.sv
// Purpose: state types for the asynchronous serial port
// Assumes: nothing
// Notes: states carry no codes
package serial_port_pkg;

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_IFS, TX_BRK
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
  } rx_state_t;

endpackage

// ===== rx_fifo_buf.sv
// Purpose: receive fifo in flip-flops with fill count
// Assumes: single clock, push and pop may coincide
// Notes: out_data reads storage by index
`include "serial_port_defs.svh"
module rx_fifo_buf #(
  parameter int WIDTH = `RX_WORD_W,
  parameter int DEPTH_LOG = `RX_FIFO_LOG
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // fill level
  output logic [DEPTH_LOG:0] count
);
  localparam int DEPTH = 1 << DEPTH_LOG;

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [DEPTH_LOG-1:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
  logic [DEPTH_LOG:0] cnt_ff, nxt_cnt;
  logic push, pop;

  assign in_ready = (cnt_ff != DEPTH[DEPTH_LOG:0]);
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rd_ff];
  assign count = cnt_ff;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
    nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  // storage has no reset
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end
endmodule

// ===== serial_port_checker.sv
// Purpose: port checker for serial_port
// Assumes: bit_div is at least 4
// Notes: frame start is a fall after nine idle bit times
module serial_port_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // control
  input wire logic [15:0] bit_div,
  input wire logic auto_flow,
  input wire logic ir_mode,
  input wire logic cts_n,
  input wire logic [3:0] err_clr,
  // data
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic tx_dma_req,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] rx_data,
  input wire logic rx_addr,
  input wire logic rx_dma_req,
  input wire logic rx_attn,
  input wire logic parity_err,
  input wire logic overrun,
  // pins
  input wire logic txd,
  input wire logic ir_txd,
  input wire logic rts_n
);
  logic [23:0] hrun_ff;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hrun_ff <= 24'h00_0000;
    end else begin
      hrun_ff <= txd ? hrun_ff + 24'h00_0001 : 24'h00_0000;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_tx_dma_mirror: assert property (tx_dma_req == tx_ready)
    else $error("tx dma request differs from ready");
  a_rx_dma_mirror: assert property (rx_dma_req == rx_valid)
    else $error("rx dma request differs from valid");
  a_take_fills_hold: assert property (tx_valid && tx_ready |=> !tx_ready)
    else $error("hold register not filled");
  a_low_bit_width: assert property ($fell(txd) |-> !txd[*3])
    else $error("low bit too short");
  a_rts_manual: assert property (!auto_flow |-> !rts_n)
    else $error("rts_n high without auto flow");
  a_cts_gates_start: assert property ($fell(txd) && auto_flow && hrun_ff > 24'(bit_div) * 24'h00_0009
    |-> !($past(cts_n) && $past(cts_n, 2))) else $error("frame started while cts_n high");
  a_attn_single: assert property (rx_attn |=> !rx_attn)
    else $error("attention longer than one cycle");
  a_attn_then_valid: assert property (rx_attn |=> rx_valid)
    else $error("stored character not offered");
  a_parity_sticky: assert property (parity_err && !err_clr[0] |=> parity_err)
    else $error("parity flag dropped");
  a_head_stable: assert property (rx_valid && !rx_ready |=> rx_valid && $stable({rx_addr, rx_data}))
    else $error("receive head changed unpopped");
  a_ir_quiet: assert property (!ir_mode |-> !ir_txd)
    else $error("infrared pulse outside infrared mode");
  c_attn: cover property (rx_attn);
  c_overrun: cover property ($rose(overrun));
  c_flow_start: cover property ($fell(txd) && auto_flow);
  c_ir_pulse: cover property ($rose(ir_txd));
endmodule

bind serial_port serial_port_checker u_chk (.sys_clk, .rst, .bit_div, .auto_flow, .ir_mode, .cts_n, .err_clr,
  .tx_valid, .tx_ready, .tx_dma_req, .rx_valid, .rx_ready, .rx_data, .rx_addr, .rx_dma_req, .rx_attn,
  .parity_err, .overrun, .txd, .ir_txd, .rts_n);

// ===== remote_node.sv
// Purpose: remote serial node at the far end of the line
// Assumes: bench sets the framing fields before use
// Notes: line stays high outside frames
module remote_node (
  // clock
  input wire logic sys_clk,
  // line
  input wire logic txd,
  input wire logic rts_n,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  int bd = 8;
  int nb = 8;
  int xb = 0;
  int ns = 1;
  int lrun = 0;
  int hrun = 0;
  int last_low = 0;
  int last_high = 0;
  logic [9:0] w;
  logic [9:0] q[$];
  initial rxd = 1'h1;
  // run lengths of the line
  always @(posedge sys_clk) begin
    lrun <= txd ? 0 : lrun + 1;
    hrun <= txd ? hrun + 1 : 0;
    if (txd && lrun > 0) last_low <= lrun;
    if (!txd && hrun > 0) last_high <= hrun;
  end
  // one frame out; xv extra bit, sv stop level
  task automatic send(input logic [7:0] d, input logic xv, input logic sv);
    while (rts_n) @(posedge sys_clk);
    rxd <= 1'h0;
    repeat (bd) @(posedge sys_clk);
    for (int i = 0; i < nb + xb; i++) begin
      rxd <= (i < nb) ? d[i] : xv;
      repeat (bd) @(posedge sys_clk);
    end
    rxd <= sv;
    repeat (bd * ns) @(posedge sys_clk);
    rxd <= 1'h1;
    repeat (bd) @(posedge sys_clk);
  endtask
  // decode frames seen on txd
  always begin
    @(negedge txd);
    repeat (bd / 2) @(posedge sys_clk);
    w = 10'h200;
    for (int i = 0; i < nb + xb; i++) begin
      repeat (bd) @(posedge sys_clk);
      w[i] = txd;
    end
    repeat (ns) begin
      repeat (bd) @(posedge sys_clk);
      w[9] = w[9] & txd;
    end
    if (!txd) @(posedge txd);
    q.push_back(w);
  end
endmodule

// ===== tb_top.sv
// Purpose: self-checking bench for serial_port
// Assumes: serial_port_defs.svh compiled first
// Notes: bit_div is 8 so frames stay short
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rst, parity_en, parity_odd, multidrop_bus_mode, two_stop, auto_flow, ir_mode;
  logic tx_valid, tx_ready, tx_addr, tx_break, tx_dma_req, rx_valid, rx_ready, rx_addr, rx_dma_req, rx_attn;
  logic parity_err, frame_err, break_seen, overrun, txd, rxd, ir_txd, ir_rxd, cts_n, rts_n;
  logic [15:0] bit_div;
  logic [1:0] word_len;
  logic [7:0] node_addr, break_len, ifs_len, tx_data, rx_data, d, d2;
  logic [4:0] rts_level;
  logic [3:0] err_clr;
  logic [9:0] w;
  int seed = 524;
  int n_errors = 0;
  int checks = 0;
  int n_attn = 0;
  int n_ir = 0;
  logic ir_q = 1'h0;
  int nb, n, a0;
  serial_port u_dut (.sys_clk, .rst, .bit_div, .word_len, .parity_en, .parity_odd, .multidrop_bus_mode,
    .node_addr, .two_stop, .auto_flow, .rts_level, .break_len, .ifs_len, .ir_mode, .tx_valid, .tx_ready,
    .tx_data, .tx_addr, .tx_break, .tx_dma_req, .rx_valid, .rx_ready, .rx_data, .rx_addr, .rx_dma_req,
    .rx_attn, .parity_err, .frame_err, .break_seen, .overrun, .err_clr, .txd, .rxd, .ir_txd, .ir_rxd,
    .cts_n, .rts_n);
  remote_node u_far (.sys_clk, .txd, .rts_n, .rxd);
  // infrared transceiver echoes the pulses back
  assign ir_rxd = ir_txd;
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (rx_attn === 1'h1) n_attn <= n_attn + 1;
  // count infrared pulses by their rising edges
  always @(posedge sys_clk) begin
    ir_q <= ir_txd;
    if (ir_txd === 1'h1 && ir_q !== 1'h1) n_ir <= n_ir + 1;
  end
  function automatic logic [9:0] frame_word(input logic [7:0] v, input logic x, input int k);
    return {1'h1, ({1'h0, v} & (9'h0FF >> (8 - k))) | (9'(x) << k)};
  endfunction
  function automatic logic par_bit(input logic [7:0] v, input int k, input logic odd);
    return ^(v & (8'hFF >> (8 - k))) ^ odd;
  endfunction
  task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic put(input logic [7:0] v, input logic a, input logic b);
    tx_data <= v;
    tx_addr <= a;
    tx_break <= b;
    tx_valid <= 1'h1;
    do @(negedge sys_clk); while (tx_ready !== 1'h1);
    @(posedge sys_clk);
    tx_valid <= 1'h0;
    @(posedge sys_clk);
  endtask
  task automatic pop(output logic [9:0] r);
    do @(negedge sys_clk); while (rx_valid !== 1'h1);
    r = {1'h0, rx_addr, rx_data};
    @(posedge sys_clk);
    rx_ready <= 1'h1;
    @(posedge sys_clk);
    rx_ready <= 1'h0;
  endtask
  task automatic flush(output int c);
    logic [9:0] r;
    c = 0;
    @(negedge sys_clk);
    while (rx_valid === 1'h1) begin
      pop(r);
      c++;
      @(negedge sys_clk);
    end
    @(posedge sys_clk);
  endtask
  task automatic summarize;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge sys_clk);
    n_errors++;
    summarize();
  end
  initial begin
    rst = 1'h1;
    {tx_valid, tx_addr, tx_break, rx_ready, parity_en, parity_odd, multidrop_bus_mode} = 7'h00;
    {two_stop, auto_flow, ir_mode, cts_n} = 4'h0;
    {bit_div, word_len, node_addr, rts_level} = {16'h0008, 2'h3, 8'h00, 5'h10};
    {break_len, ifs_len, tx_data, err_clr} = {8'h01, 8'h00, 8'h00, 4'h0};
    repeat (12) @(posedge sys_clk);
    rst <= 1'h0;
    @(posedge sys_clk);
    for (int m = 0; m < 12; m++) begin
      nb = 5 + m % 4;
      {word_len, parity_en, parity_odd, two_stop} <= {2'(m % 4), m > 3, m > 7, m[0]};
      {u_far.nb, u_far.xb, u_far.ns} = {nb, int'(m > 3), 1 + m % 2};
      d = 8'($random(seed));
      d2 = 8'($random(seed));
      @(posedge sys_clk);
      fork
        put(d, 1'h0, 1'h0);
        u_far.send(d2, par_bit(d2, nb, m > 7), 1'h1);
      join
      pop(w);
      chk("rx word", w, frame_word(d2, 1'h0, nb) & 10'h1FF);
      wait (u_far.q.size() != 0);
      chk("tx frame", u_far.q.pop_front(), frame_word(d, par_bit(d, nb, m > 7) & (m > 3), nb));
      repeat (24) @(posedge sys_clk);
    end
    {word_len, parity_odd, two_stop} <= {2'h3, 1'h0, 1'h0};
    {u_far.nb, u_far.xb, u_far.ns} = {32'd8, 32'd1, 32'd1};
    @(posedge sys_clk);
    u_far.send(8'h0F, 1'h1, 1'h1);
    chk("parity flag", 10'(parity_err), 10'h1);
    u_far.send(8'h0F, 1'h0, 1'h0);
    chk("frame flag", 10'(frame_err), 10'h1);
    u_far.send(8'h00, 1'h0, 1'h0);
    chk("break flag", 10'(break_seen), 10'h1);
    flush(n);
    err_clr <= 4'hF;
    @(posedge sys_clk);
    err_clr <= 4'h0;
    @(negedge sys_clk);
    chk("flags cleared", 10'({parity_err, frame_err, break_seen, overrun}), 10'h0);
    for (int i = 0; i < 17; i++) begin
      if (i == 16) chk("overrun early", 10'(overrun), 10'h0);
      u_far.send(8'(i), par_bit(8'(i), 8, 1'h0), 1'h1);
    end
    chk("overrun", 10'(overrun), 10'h1);
    flush(n);
    chk("fifo depth", 10'(n), 10'h10);
    {auto_flow, rts_level} <= {1'h1, 5'h03};
    @(posedge sys_clk);
    repeat (3) u_far.send(8'h3C, 1'h0, 1'h1);
    chk("rts at level", 10'(rts_n), 10'h1);
    cts_n <= 1'h1;
    put(8'hA5, 1'h0, 1'h0);
    repeat (200) @(posedge sys_clk);
    chk("held by cts", 10'(u_far.q.size()), 10'h0);
    cts_n <= 1'h0;
    wait (u_far.q.size() != 0);
    chk("sent after cts", u_far.q.pop_front(), frame_word(8'hA5, par_bit(8'hA5, 8, 1'h0), 8));
    flush(n);
    chk("rts below level", 10'(rts_n), 10'h0);
    {auto_flow, multidrop_bus_mode, parity_en, node_addr} <= {1'h0, 1'h1, 1'h0, 8'h5A};
    a0 = n_attn;
    @(posedge sys_clk);
    fork
      put(8'h77, 1'h1, 1'h0);
      begin
        u_far.send(8'h33, 1'h1, 1'h1);
        u_far.send(8'h11, 1'h0, 1'h1);
        u_far.send(8'h5A, 1'h1, 1'h1);
        u_far.send(8'h22, 1'h0, 1'h1);
      end
    join
    chk("attention count", 10'(n_attn - a0), 10'h2);
    pop(w);
    chk("own address", w, 10'h15A);
    pop(w);
    chk("addressed data", w, 10'h022);
    wait (u_far.q.size() != 0);
    chk("tx address bit", u_far.q.pop_front(), frame_word(8'h77, 1'h1, 8));
    {multidrop_bus_mode, ifs_len, break_len} <= {1'h0, 8'h02, 8'h0C};
    u_far.xb = 0;
    @(posedge sys_clk);
    put(8'h00, 1'h0, 1'h0);
    put(8'h00, 1'h0, 1'h1);
    wait (u_far.q.size() == 2);
    repeat (4) @(posedge sys_clk);
    chk("data before break", u_far.q.pop_front(), 10'h200);
    chk("break frame", u_far.q.pop_front(), 10'h000);
    chk("break length", 10'(u_far.last_low), 10'(12 * 8));
    chk("frame gap", 10'(u_far.last_high), 10'(3 * 8 + 1));
    ir_mode <= 1'h1;
    @(posedge sys_clk);
    put(8'h96, 1'h0, 1'h0);
    wait (u_far.q.size() != 0);
    chk("ir line frame", u_far.q.pop_front(), frame_word(8'h96, 1'h0, 8));
    pop(w);
    chk("ir loopback", w, 10'h096);
    chk("ir pulses", 10'(n_ir), 10'(1 + 8 - $countones(8'h96)));
    summarize();
  end
endmodule
